// ===== hw/spmp_port.v
// What this block does
// - programming works only while the device reset pin is held low
// - program and erase refused until programming enable is executed
// - every eeprom write overwrites the target byte directly, with no separate erase step
// - chip erase sets all flash and eeprom bytes to ff
// - incoming mosi data sampled on rising sck edge
// - outgoing miso data shifted on falling sck edge
// - enable second byte echoes during third byte; programmer retries on mismatch (the testbench enable task only checks the echo)
// - flash page buffer loaded bytewise with low word address bits
// - write page instruction commits buffer to flash page
// - eeprom byte write overwrites the byte at once; 4.0 ms wait
// - eeprom page buffer loaded by two low bits, committed by page write
// - eeprom page write changes only loaded bytes
// - read instruction returns addressed flash or eeprom byte on miso
// - reset pin high leaves programming mode and starts normal run
// - flash page 32 words by default, word index low bits
// - eeprom page four bytes, two low address bits pick the byte
// - enable is four bytes: ac, 53, two don't-care bytes
// - poll returns busy flag in fourth byte lsb
`timescale 1ns/100ps
`include "spmp_defines.vh"
module spmp_port #(
  parameter FLASH_AW  = 12,
  parameter PAGE_AW   = 5,
  parameter EE_AW     = 9,
  parameter DLY_W     = 20,
  parameter FLASH_DLY = (`SPMP_T_FLASH_NS + `SPMP_CLK_NS - 1) / `SPMP_CLK_NS,
  parameter EE_DLY    = (`SPMP_T_EEPROM_NS + `SPMP_CLK_NS - 1) / `SPMP_CLK_NS,
  parameter ERASE_DLY = (`SPMP_T_ERASE_NS + `SPMP_CLK_NS - 1) / `SPMP_CLK_NS
) (
  input  wire clk,
  input  wire rst,
  input  wire reset_pin_n,
  input  wire sck,
  input  wire mosi,
  output wire miso,
  output wire miso_oe,
  output wire prog_mode,
  output wire cpu_run,
  output wire busy_poll_flag
);

  localparam FB_AW = FLASH_AW + 1;
  localparam PB_AW = PAGE_AW + 1;
  localparam EW    = (FB_AW > EE_AW) ? FB_AW : EE_AW;
  localparam SEL_W = FLASH_AW - PAGE_AW;
  localparam EP_W  = EE_AW - `SPMP_EE_PAGE_AW;

  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_FLASH = 5'b00010;
  localparam [4:0] ST_EE    = 5'b00100;
  localparam [4:0] ST_ERASE = 5'b01000;
  localparam [4:0] ST_WAIT  = 5'b10000;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [2:0] sck_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [1:0] rstn_sync_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_sync_reg  <= 3'h0;
      mosi_sync_reg <= 2'h0;
      rstn_sync_reg <= 2'h3;
    end else begin
      sck_sync_reg  <= {sck_sync_reg[1:0], sck};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi};
      rstn_sync_reg <= {rstn_sync_reg[0], reset_pin_n};
    end
  end

  wire mosi_s   = mosi_sync_reg[1];
  // sck phases over two cpu cycles keep these edges apart
  wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  wire in_prog  = ~rstn_sync_reg[1];

  assign prog_mode = in_prog;
  assign cpu_run   = ~in_prog;

  //////////////////////////////////////////////////////////////////////////
  // serial shifter
  reg  [4:0]  bit_reg;
  reg  [31:0] rx_reg;
  reg         enabled_reg;
  reg         miso_reg;
  reg  [6:0]  tx_reg;
  reg  [4:0]  state_reg;

  wire [31:0] word_in    = {rx_reg[30:0], mosi_s};
  wire        frame_done = in_prog & sck_rise & (bit_reg == 5'h1f);
  wire [7:0]  b1 = word_in[31:24];
  wire [7:0]  b2 = word_in[23:16];
  wire [7:0]  b3 = word_in[15:8];
  wire [7:0]  b4 = word_in[7:0];
  wire        busy = (state_reg != ST_IDLE);

  assign busy_poll_flag = busy;

  // only realignment is leaving programming mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_reg <= 5'h00;
      rx_reg  <= 32'h00000000;
    end else if (!in_prog) begin
      bit_reg <= 5'h00;
    end else if (sck_rise) begin
      rx_reg  <= word_in; // msb first, on rising edge
      bit_reg <= bit_reg + 5'h01;
    end
  end

  // enable accepted only while reset pin low; cleared on exit
  wire enable_cmd = frame_done & (b1 == `SPMP_OP_ENABLE) &
                    (b2 == `SPMP_ENABLE_KEY);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enabled_reg <= 1'b0;
    end else if (!in_prog) begin
      enabled_reg <= 1'b0;
    end else if (enable_cmd) begin
      enabled_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // memories
  wire [7:0] fl_rdata;
  wire [7:0] ee_rdata;
  wire [7:0] pb_rdata;
  reg        fl_we;
  reg  [FB_AW-1:0] fl_waddr;
  reg  [7:0] fl_wdata;
  reg        ee_we;
  reg  [EE_AW-1:0] ee_waddr;
  reg  [7:0] ee_wdata;

  reg  [EW:0]      walk_reg;
  reg  [SEL_W-1:0] fl_page_reg;
  reg  [EP_W-1:0]  ee_page_reg;
  reg  [(1<<PB_AW)-1:0] fl_mask_reg;
  reg  [3:0]       ee_mask_reg;
  reg  [31:0]      ee_buf_reg;
  reg  [DLY_W-1:0] dly_reg;

  // every command but enable, poll and the reads waits for enable and idle
  wire cmd_ok = frame_done & enabled_reg & ~busy;
  wire op_erase = cmd_ok & (b1 == `SPMP_OP_ENABLE) &
                  (b2[7:5] == `SPMP_ERASE_KEY);
  wire op_ld_fl = cmd_ok & ((b1 == `SPMP_OP_LD_FL_LO) |
                            (b1 == `SPMP_OP_LD_FL_HI));
  wire op_wr_fl = cmd_ok & (b1 == `SPMP_OP_WR_FL_PAGE);
  wire op_wr_ee = cmd_ok & (b1 == `SPMP_OP_WR_EE);
  wire op_ld_ee = cmd_ok & (b1 == `SPMP_OP_LD_EE_PAGE);
  wire op_pg_ee = cmd_ok & (b1 == `SPMP_OP_WR_EE_PAGE);

  // page buffer byte address is {word index, high/low}
  wire [PB_AW-1:0] pb_waddr = {b3[PAGE_AW-1:0], b1[3]};
  wire [PB_AW-1:0] walk_idx = walk_reg[PB_AW-1:0] - {{(PB_AW-1){1'b0}}, 1'b1};
  wire [1:0]       ee_idx   = walk_reg[1:0];

  spmp_mem #(.DW(8), .AW(PB_AW)) u_page_buf (
    .clk   (clk),
    .we    (op_ld_fl),
    .waddr (pb_waddr),
    .wdata (b4),
    .raddr (walk_reg[PB_AW-1:0]),
    .rdata (pb_rdata)
  );

  // read address tracks bytes 2 and 3 once they have arrived
  spmp_mem #(.DW(8), .AW(FB_AW)) u_flash (
    .clk   (clk),
    .we    (fl_we),
    .waddr (fl_waddr),
    .wdata (fl_wdata),
    .raddr ({rx_reg[FLASH_AW-1:0], rx_reg[19]}),
    .rdata (fl_rdata)
  );

  spmp_mem #(.DW(8), .AW(EE_AW)) u_eeprom (
    .clk   (clk),
    .we    (ee_we),
    .waddr (ee_waddr),
    .wdata (ee_wdata),
    .raddr (rx_reg[EE_AW-1:0]),
    .rdata (ee_rdata)
  );

  // a write simply overwrites the cell, so erase is implied
  always @* begin
    fl_we    = 1'b0;
    fl_waddr = {fl_page_reg, walk_idx};
    fl_wdata = pb_rdata;
    ee_we    = 1'b0;
    ee_waddr = {ee_page_reg, ee_idx};
    ee_wdata = ee_buf_reg[{ee_idx, 3'h0} +: 8];
    case (state_reg)
      ST_FLASH: fl_we = (|walk_reg) & fl_mask_reg[walk_idx];
      ST_EE:    ee_we = ee_mask_reg[ee_idx];
      ST_ERASE: begin
        fl_we    = (walk_reg < (1 << FB_AW));
        fl_waddr = walk_reg[FB_AW-1:0];
        fl_wdata = `SPMP_ERASED;
        ee_we    = (walk_reg < (1 << EE_AW));
        ee_waddr = walk_reg[EE_AW-1:0];
        ee_wdata = `SPMP_ERASED;
      end
      ST_IDLE: begin
        ee_we    = op_wr_ee;
        ee_waddr = word_in[8+EE_AW-1:8];
        ee_wdata = b4;
      end
      default: fl_we = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // self-timed write sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      walk_reg    <= {(EW+1){1'b0}};
      dly_reg     <= {DLY_W{1'b0}};
      fl_page_reg <= {SEL_W{1'b0}};
      ee_page_reg <= {EP_W{1'b0}};
      fl_mask_reg <= {(1<<PB_AW){1'b0}};
      ee_mask_reg <= 4'h0;
      ee_buf_reg  <= 32'h00000000;
    end else begin
      if (dly_reg != {DLY_W{1'b0}}) begin
        dly_reg <= dly_reg - {{(DLY_W-1){1'b0}}, 1'b1};
      end
      case (state_reg)
        ST_IDLE: begin
          walk_reg <= {(EW+1){1'b0}};
          if (op_ld_fl) fl_mask_reg[pb_waddr] <= 1'b1;
          if (op_ld_ee) begin
            ee_buf_reg[{b3[1:0], 3'h0} +: 8] <= b4;
            ee_mask_reg[b3[1:0]] <= 1'b1;
          end
          if (op_wr_fl) begin
            // word address bits above the page index pick the page
            fl_page_reg <= word_in[8+FLASH_AW-1:8+PAGE_AW];
            dly_reg     <= FLASH_DLY[DLY_W-1:0];
            state_reg   <= ST_FLASH;
          end else if (op_pg_ee) begin
            ee_page_reg <= word_in[8+EE_AW-1:8+`SPMP_EE_PAGE_AW];
            dly_reg     <= EE_DLY[DLY_W-1:0];
            state_reg   <= ST_EE;
          end else if (op_wr_ee) begin
            dly_reg   <= EE_DLY[DLY_W-1:0];
            state_reg <= ST_WAIT;
          end else if (op_erase) begin
            dly_reg   <= ERASE_DLY[DLY_W-1:0];
            state_reg <= ST_ERASE;
          end
        end
        ST_FLASH: begin
          // one extra step drains the registered buffer read
          walk_reg <= walk_reg + {{EW{1'b0}}, 1'b1};
          if (walk_reg == (1 << PB_AW)) begin
            fl_mask_reg <= {(1<<PB_AW){1'b0}};
            state_reg   <= ST_WAIT;
          end
        end
        ST_EE: begin
          walk_reg <= walk_reg + {{EW{1'b0}}, 1'b1};
          if (ee_idx == 2'h3) begin
            ee_mask_reg <= 4'h0;
            state_reg   <= ST_WAIT;
          end
        end
        ST_ERASE: begin
          walk_reg <= walk_reg + {{EW{1'b0}}, 1'b1};
          if (walk_reg == (1 << EW) - 1) state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (dly_reg == {DLY_W{1'b0}}) state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output byte selection and shifting
  reg [7:0] out_byte;

  always @* begin
    out_byte = 8'h00;
    case (bit_reg[4:3])
      2'h1, 2'h2: out_byte = rx_reg[7:0]; // byte 2 echoes in byte 3
      2'h3: begin
        case (rx_reg[23:16])
          `SPMP_OP_RD_FL_LO: out_byte = fl_rdata;
          `SPMP_OP_RD_FL_HI: out_byte = fl_rdata;
          `SPMP_OP_RD_EE:    out_byte = ee_rdata;
          `SPMP_OP_POLL:     out_byte = {7'h00, busy};
          default:           out_byte = 8'h00;
        endcase
      end
      default: out_byte = 8'h00;
    endcase
  end

  // read data settle two clocks after the rise, well before the fall
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      miso_reg <= 1'b0;
      tx_reg   <= 7'h00;
    end else if (!in_prog) begin
      miso_reg <= 1'b0;
      tx_reg   <= 7'h00;
    end else if (sck_fall) begin
      if (bit_reg[2:0] == 3'h0) begin
        miso_reg <= out_byte[7];
        tx_reg   <= out_byte[6:0];
      end else begin
        miso_reg <= tx_reg[6];
        tx_reg   <= {tx_reg[5:0], 1'b0};
      end
    end
  end

  assign miso    = miso_reg;
  assign miso_oe = in_prog;

endmodule // spmp_port

// ===== hw/spmp_defines.vh
`ifndef SPMP_DEFINES_VH
`define SPMP_DEFINES_VH

// clock period of the block clock
`define SPMP_CLK_NS         40

// self-timed write delays, in ns
`define SPMP_T_FLASH_NS     4500000
`define SPMP_T_EEPROM_NS    4000000
`define SPMP_T_ERASE_NS     4000000

// instruction opcodes, first byte
`define SPMP_OP_ENABLE      8'hac
`define SPMP_OP_RD_FL_LO    8'h20
`define SPMP_OP_RD_FL_HI    8'h28
`define SPMP_OP_LD_FL_LO    8'h40
`define SPMP_OP_LD_FL_HI    8'h48
`define SPMP_OP_WR_FL_PAGE  8'h4c
`define SPMP_OP_RD_EE       8'ha0
`define SPMP_OP_WR_EE       8'hc0
`define SPMP_OP_LD_EE_PAGE  8'hc1
`define SPMP_OP_WR_EE_PAGE  8'hc2
`define SPMP_OP_POLL        8'hf0

// second byte codes under the enable opcode
`define SPMP_ENABLE_KEY     8'h53
`define SPMP_ERASE_KEY      3'h4

// erased cell value
`define SPMP_ERASED         8'hff

// eeprom page: index bits
`define SPMP_EE_PAGE_AW     2

`endif

// ===== hw/spmp_mem.v
`timescale 1ns/100ps
// simple dual-port array, read data registered
module spmp_mem #(
  parameter DW = 8,
  parameter AW = 8
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // spmp_mem

// ===== tb/spmp_port_assertions.sv
`timescale 1ns/100ps
module spmp_port_checker #(
  parameter FLASH_DLY = 20,
  parameter EE_DLY    = 20,
  parameter ERASE_DLY = 20
) (
  input wire clk,
  input wire rst,
  input wire reset_pin_n,
  input wire sck,
  input wire mosi,
  input wire miso,
  input wire miso_oe,
  input wire prog_mode,
  input wire cpu_run,
  input wire busy_poll_flag
);
  localparam int MIN_BUSY = (FLASH_DLY < EE_DLY ? FLASH_DLY : EE_DLY) - 4;
  // loose ceiling: erase walk plus every delay
  localparam int MAX_BUSY = 8192 + FLASH_DLY + EE_DLY + ERASE_DLY;
  integer busy_cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_poll_flag ? busy_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  run_inverse_a: assert property (cpu_run == !prog_mode)
    else $error("cpu run does not mirror programming mode");
  mode_entry_a: assert property (!reset_pin_n [*4] |-> prog_mode)
    else $error("programming mode missing with reset pin low");
  mode_exit_a: assert property (reset_pin_n [*4] |-> !prog_mode)
    else $error("programming mode kept with reset pin high");
  oe_mode_a: assert property (miso_oe == prog_mode)
    else $error("output enable differs from programming mode");
  miso_fall_a: assert property (prog_mode && $changed(miso)
    |-> $past(sck, 4) && !$past(sck, 3))
    else $error("serial output changed away from a falling clock");
  busy_rise_a: assert property ($rose(busy_poll_flag)
    |-> prog_mode && $past(sck, 2)) else $error("busy rose off a rise");
  busy_min_a: assert property ($fell(busy_poll_flag)
    |-> busy_cnt >= MIN_BUSY) else $error("busy too short");
  busy_max_a: assert property (busy_poll_flag |-> busy_cnt < MAX_BUSY)
    else $error("busy too long");
  idle_start_a: assert property (!prog_mode && !busy_poll_flag
    |=> !busy_poll_flag) else $error("operation started outside mode");
  cover property ($rose(busy_poll_flag));
  cover property ($fell(prog_mode));
  cover property (prog_mode && $changed(miso));
endmodule // spmp_port_checker

bind spmp_port spmp_port_checker #(.FLASH_DLY(FLASH_DLY), .EE_DLY(EE_DLY),
  .ERASE_DLY(ERASE_DLY)) u_chk (.clk(clk), .rst(rst),
  .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .prog_mode(prog_mode), .cpu_run(cpu_run),
  .busy_poll_flag(busy_poll_flag));

// ===== tb/spmp_prog_model.sv
`timescale 1ns/100ps
// programmer: spi master owning reset pin, sck and mosi
module spmp_prog_model #(
  parameter PWR_WAIT = 50
) (
  input  wire clk,
  output reg  reset_pin_n,
  output reg  sck,
  output reg  mosi,
  input  wire miso
);
  initial begin
    reset_pin_n = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // power-up wait scaled down, the real one would dwarf the run
  task power_wait;
    begin
      repeat (PWR_WAIT) @(posedge clk);
    end
  endtask
  // pin level held 8 clk, well over two cpu cycles
  task set_pin(input v);
    begin
      reset_pin_n <= v;
      repeat (8) @(posedge clk);
    end
  endtask
  // n bits msb first, 4 clk per phase; sck idles low between frames
  task shift(input [31:0] cmd, input integer n, output [31:0] resp);
    integer i;
    begin
      resp = 32'h0;
      for (i = 31; i > 31 - n; i = i - 1) begin
        mosi <= cmd[i];
        repeat (4) @(posedge clk);
        resp[i] = miso;
        sck <= 1'b1;
        repeat (4) @(posedge clk);
        sck <= 1'b0;
      end
      mosi <= ~cmd[32 - n];
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // spmp_prog_model

// ===== tb/tb_serial_memory_programming_port.sv
`timescale 1ns/100ps
module tb_serial_memory_programming_port;
  localparam DLY = 600;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  wire        reset_pin_n, sck, mosi, miso, busy, prog_mode, cpu_run, miso_oe;
  integer     fail_count = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  integer     i, k;
  reg  [31:0] seed = 32'h00008d04;
  reg  [31:0] r;
  reg  [7:0]  ee [0:511];
  reg  [8:0]  ea;
  reg  [6:0]  pg;
  reg  [4:0]  w;
  always #20 clk = ~clk;
  spmp_port #(.FLASH_DLY(DLY), .EE_DLY(DLY), .ERASE_DLY(DLY)) i_dut (
    .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .sck(sck),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .prog_mode(prog_mode),
    .cpu_run(cpu_run), .busy_poll_flag(busy));
  spmp_prog_model i_prog (.clk(clk), .reset_pin_n(reset_pin_n),
    .sck(sck), .mosi(mosi), .miso(miso));
  ////////////////////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task cmd(input [31:0] c);
    begin
      i_prog.shift(c, 32, r);
    end
  endtask
  task enable;
    begin
      cmd(32'hac53_0000);
      check(r[15:8], 8'h53);
    end
  endtask
  // polling is bounded so a stuck flag cannot hang the run
  task poll_idle;
    integer n;
    begin
      n = 0;
      cmd(32'hf000_0000);
      check(r[0], 1);
      while (r[0] !== 1'b0 && n < 60) begin
        cmd(32'hf000_0000);
        n = n + 1;
      end
      check(busy, 0);
    end
  endtask
  task rd_ee(input [8:0] a);
    begin
      cmd({8'ha0, 7'h0, a, 8'h00});
      check(r[7:0], ee[a]);
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    i_prog.power_wait;
    check(prog_mode, 1);
    check(cpu_run, 0);
    check(miso_oe, 1);
    cmd(32'hac80_0000);
    check(busy, 0);
    enable;
    cmd(32'hac80_0000);
    poll_idle;
    for (i = 0; i < 512; i = i + 1) ee[i] = 8'hff;
    i_prog.set_pin(1'b1);
    check(cpu_run, 1);
    check(prog_mode, 0);
    check(miso_oe, 0);
    i_prog.set_pin(1'b0);
    cmd(32'hc000_2a00);
    check(busy, 0);
    i_prog.shift(32'hac53_0000, 5, r);
    i_prog.set_pin(1'b1); // a torn frame is cleared only by the pin
    i_prog.set_pin(1'b0);
    enable;
    rd_ee(9'h02a);
    for (k = 0; k < 6; k = k + 1) begin
      seed = xs(seed);
      ea = (k < 2) ? 9'h1fd : seed[8:0];
      ee[ea] = (k == 0) ? 8'h00 : seed[23:16];
      cmd({8'hc0, 7'h0, ea, ee[ea]});
      check(busy, 1);
      poll_idle;
      rd_ee(ea);
    end
    seed = xs(seed);
    pg = 7'h7f;
    for (k = 0; k < 4; k = k + 3) begin
      ee[{pg, k[1:0]}] = seed[k*8 +: 8];
      cmd({8'hc1, 14'h0, k[1:0], seed[k*8 +: 8]});
    end
    cmd({8'hc2, 7'h0, pg, 2'b00, 8'h00});
    poll_idle;
    for (k = 0; k < 4; k = k + 1) rd_ee({pg, k[1:0]});
    seed = xs(seed);
    pg = seed[11:5];
    for (k = 0; k < 4; k = k + 1) begin
      w = k[1] ? 5'h1f : 5'h00;
      cmd({4'h4, k[0], 3'h0, 8'h00, 3'h0, w, seed[k*8 +: 8]});
    end
    cmd({8'h4c, 4'h0, pg, 5'h0, 8'h00});
    check(busy, 1);
    poll_idle;
    for (k = 0; k < 4; k = k + 1) begin
      w = k[1] ? 5'h1f : 5'h00;
      cmd({4'h2, k[0], 3'h0, 4'h0, pg, w, 8'h00});
      check(r[7:0], seed[k*8 +: 8]);
    end
    cmd({8'h20, 4'h0, pg, 5'h01, 8'h00});
    check(r[7:0], 8'hff);
    tally_and_finish;
  end
endmodule // tb_serial_memory_programming_port
